// file: pkg/tps_pkg.sv
/*
 * Shared constants for the trace port control block: register map,
 * control field layout, reset values and port-width and format codes.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package tps_pkg;
    localparam int          AXI_AW         = 12;
    localparam int          STRAP_W        = 8;
    localparam int          PIPE_W         = 3;
    localparam int          PKT_W          = 16;
    localparam int          CTX_W          = 32;

    localparam logic [11:0] OFS_CTRL       = 12'h000;
    localparam logic [11:0] OFS_STRAPS     = 12'h004;
    localparam logic [11:0] OFS_CONTEXT    = 12'h008;

    localparam int          CTRL_EN_BIT    = 0;
    localparam int          CTRL_WIDTH_LSB = 4;
    localparam int          CTRL_HALF_BIT  = 8;
    localparam int          CTRL_FMT_LSB   = 16;
    localparam logic [31:0] CTRL_WMASK     = 32'h0003_0171;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

    localparam logic [2:0]  WIDTH_4BIT     = 3'h0;
    localparam logic [2:0]  WIDTH_8BIT     = 3'h1;
    localparam logic [2:0]  WIDTH_16BIT    = 3'h2;
    localparam logic [1:0]  FMT_NORMAL     = 2'h0;
    localparam logic [1:0]  FMT_MUXED      = 2'h1;
    localparam logic [1:0]  FMT_DEMUXED    = 2'h2;

    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

// file: pkg/tps_reg_if.sv
/*
 * Internal register access path between the AXI4-Lite slave and the
 * trace port control core. Single clock; write is a one-cycle pulse,
 * read is a combinational lookup.
 */
`timescale 1ns/100ps
`default_nettype none
interface tps_reg_if;
    logic        wr_en;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_err;
    logic [11:0] rd_addr;
    logic [31:0] rd_data;
    logic        rd_err;

    modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                  input  wr_err, rd_data, rd_err);
    modport regs (input  wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                  output wr_err, rd_data, rd_err);
endinterface
`default_nettype wire

// file: hdl/tps_axil_slave.sv
/*
 * AXI4-Lite slave front end for the trace port control registers.
 * Assumes one write and one read in flight at most; unmapped
 * addresses answer SLVERR, decided by the register core.
 */
`timescale 1ns/100ps
`default_nettype none
module tps_axil_slave
    import tps_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [AXI_AW-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [AXI_AW-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    tps_reg_if.bus                 rg
);
    typedef struct packed {
        logic        aw_got;
        logic        w_got;
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0]  strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } tps_axil_state_type;

    tps_axil_state_type q;
    tps_axil_state_type d;
    logic               wr_fire;

    assign awready    = !q.aw_got && !q.bvalid;
    assign wready     = !q.w_got && !q.bvalid;
    assign arready    = !q.rvalid;
    assign wr_fire    = q.aw_got && q.w_got;
    assign bvalid     = q.bvalid;
    assign bresp      = q.bresp;
    assign rvalid     = q.rvalid;
    assign rdata      = q.rdata;
    assign rresp      = q.rresp;
    assign rg.wr_en   = wr_fire;
    assign rg.wr_addr = q.addr;
    assign rg.wr_data = q.data;
    assign rg.wr_strb = q.strb;
    assign rg.rd_addr = araddr;

    always_comb begin
        d = q;
        if (awvalid && awready) begin
            d.aw_got = 1'b1;
            d.addr   = awaddr;
        end
        if (wvalid && wready) begin
            d.w_got = 1'b1;
            d.data  = wdata;
            d.strb  = wstrb;
        end
        // Address and data are both held: commit, then answer
        if (wr_fire) begin
            d.aw_got = 1'b0;
            d.w_got  = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = rg.wr_err ? RESP_SLVERR : RESP_OKAY;
        end
        if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
        end
        if (arvalid && arready) begin
            d.rvalid = 1'b1;
            d.rdata  = rg.rd_data;
            d.rresp  = rg.rd_err ? RESP_SLVERR : RESP_OKAY;
        end
        if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_bvalid_hold;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped before bready");

    property p_write_answer;
        awvalid && awready && wvalid && wready |-> ##2 bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("write answer not two cycles after accept");

    property p_read_answer;
        arvalid && arready |=> rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer not one cycle after accept");

    property p_rvalid_hold;
        rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
    endproperty
    a_rvalid_hold: assert property (p_rvalid_hold) else $error("rvalid dropped before rready");
endmodule
`default_nettype wire

// file: hdl/tps_trace_port_ctrl.sv
/*
 * Trace port control core: capability straps, trace control register,
 * registered trace outputs and port configuration outputs for the
 * on-chip pin-sharing and trace clock logic.
 * Assumes trace data and context inputs are on aclk; straps are pins.
 */
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Eight strap pins are readable by software; the integrator ties them.
// - Trace status, sync and packet go out with enable, width and format.
// - After reset enable is low and width select is 000.
// - Enable and width change only on a trace control register write.
// - Half-rate enable output asks the system to halve the sample clock.
// - Format select copies control bits 17:16.
module tps_trace_port_ctrl
    import tps_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [AXI_AW-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [AXI_AW-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic [STRAP_W-1:0] capability_straps,
    input  wire logic [PIPE_W-1:0] pipeline_status_in,
    input  wire logic              trace_sync_in,
    input  wire logic [PKT_W-1:0]  trace_packet_in,
    input  wire logic [CTX_W-1:0]  context_id_in,
    input  wire logic              context_id_write,
    output logic [PIPE_W-1:0]      pipeline_status_out,
    output logic                   trace_sync_out,
    output logic [PKT_W-1:0]       trace_packet_out,
    output logic                   trace_port_enable,
    output logic [2:0]             port_width_select,
    output logic [1:0]             port_format_select,
    output logic                   half_rate_enable
);
    typedef struct packed {
        logic [STRAP_W-1:0] strap_meta;
        logic [STRAP_W-1:0] strap_sync;
        logic [31:0]        ctrl;
        logic [CTX_W-1:0]   ctx;
        logic [PIPE_W-1:0]  pipe;
        logic               sync;
        logic [PKT_W-1:0]   pkt;
    } tps_core_state_type;

    tps_core_state_type q;
    tps_core_state_type d;
    tps_reg_if          rg ();

    tps_axil_slave u_axil (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .rg      (rg.bus)
    );

    logic ctrl_write;
    assign ctrl_write = rg.wr_en && (rg.wr_addr == OFS_CTRL);

    assign trace_port_enable   = q.ctrl[CTRL_EN_BIT];
    assign port_width_select   = q.ctrl[CTRL_WIDTH_LSB +: 3];
    assign port_format_select  = q.ctrl[CTRL_FMT_LSB +: 2];
    assign half_rate_enable    = q.ctrl[CTRL_HALF_BIT];
    assign pipeline_status_out = q.pipe;
    assign trace_sync_out      = q.sync;
    assign trace_packet_out    = q.pkt;

    // Writes to read-only registers are ignored, unmapped ones refused
    assign rg.wr_err = !(rg.wr_addr == OFS_CTRL || rg.wr_addr == OFS_STRAPS
                         || rg.wr_addr == OFS_CONTEXT);

    always_comb begin
        rg.rd_data = 32'h0000_0000;
        rg.rd_err  = 1'b0;
        case (rg.rd_addr)
            OFS_CTRL: begin
                rg.rd_data = q.ctrl;
            end
            OFS_STRAPS: begin
                rg.rd_data = {24'h00_0000, q.strap_sync};
            end
            OFS_CONTEXT: begin
                rg.rd_data = q.ctx;
            end
            default: begin
                rg.rd_err = 1'b1;
            end
        endcase
    end

    always_comb begin
        d            = q;
        d.strap_meta = capability_straps;
        d.strap_sync = q.strap_meta;
        // only a control write moves enable and width
        if (ctrl_write) begin
            for (int i = 0; i < 4; i++) begin
                if (rg.wr_strb[i]) begin
                    d.ctrl[8*i +: 8] = (rg.wr_data[8*i +: 8] & CTRL_WMASK[8*i +: 8])
                                     | (q.ctrl[8*i +: 8] & ~CTRL_WMASK[8*i +: 8]);
                end
            end
        end
        // tied-low strobe leaves the capture at zero
        if (context_id_write) begin
            d.ctx = context_id_in;
        end
        // trace streams out while enabled, idle low otherwise
        if (q.ctrl[CTRL_EN_BIT]) begin
            d.pipe = pipeline_status_in;
            d.sync = trace_sync_in;
            d.pkt  = trace_packet_in;
        end else begin
            d.pipe = '0;
            d.sync = 1'b0;
            d.pkt  = '0;
        end
    end

    // reset disables port at 4-bit width
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q      <= '0;
            q.ctrl <= CTRL_RESET;
        end else begin
            q <= d;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_reset_state;
        $rose(aresetn) |-> !trace_port_enable && port_width_select == WIDTH_4BIT;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("port not disabled at 4-bit after reset");

    property p_cfg_only_on_write;
        !ctrl_write |=> $stable(trace_port_enable) && $stable(port_width_select);
    endproperty
    a_cfg_only_on_write: assert property (p_cfg_only_on_write) else $error("config moved without write");

    sequence s_full_ctrl_write;
        ctrl_write && rg.wr_strb == 4'hF;
    endsequence

    property p_cfg_takes_write;
        s_full_ctrl_write |=> trace_port_enable == $past(rg.wr_data[CTRL_EN_BIT])
            && port_width_select == $past(rg.wr_data[CTRL_WIDTH_LSB +: 3]);
    endproperty
    a_cfg_takes_write: assert property (p_cfg_takes_write) else $error("config did not take written value");

    property p_format_copy;
        s_full_ctrl_write |=> port_format_select == $past(rg.wr_data[CTRL_FMT_LSB +: 2]);
    endproperty
    a_format_copy: assert property (p_format_copy) else $error("format select not bits 17:16");

    property p_half_rate;
        s_full_ctrl_write |=> half_rate_enable == $past(rg.wr_data[CTRL_HALF_BIT]);
    endproperty
    a_half_rate: assert property (p_half_rate) else $error("half-rate enable not from control");

    sequence s_straps_steady;
        $stable(capability_straps) [*3];
    endsequence

    property p_straps_read;
        s_straps_steady ##0 rg.rd_addr == OFS_STRAPS |-> rg.rd_data == {24'h00_0000, capability_straps};
    endproperty
    a_straps_read: assert property (p_straps_read) else $error("strap readback wrong");

    property p_trace_pass;
        trace_port_enable |=> pipeline_status_out == $past(pipeline_status_in)
            && trace_sync_out == $past(trace_sync_in) && trace_packet_out == $past(trace_packet_in);
    endproperty
    a_trace_pass: assert property (p_trace_pass) else $error("trace data not passed one cycle later");

    property p_trace_idle;
        !trace_port_enable |=> pipeline_status_out == '0 && !trace_sync_out && trace_packet_out == '0;
    endproperty
    a_trace_idle: assert property (p_trace_idle) else $error("trace outputs active while disabled");
endmodule
`default_nettype wire

// file: tb/tps_capture_model.sv
/*
 * Model of the external capture analyzer and the system's trace clock.
 * Assumes the trace outputs are launched on the rising edge of aclk.
 */
`timescale 1ns/100ps
`default_nettype none
module tps_capture_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        half_rate_enable,
    input  wire logic        trace_port_enable,
    input  wire logic [2:0]  pipeline_status_out,
    input  wire logic        trace_sync_out,
    input  wire logic [15:0] trace_packet_out,
    input  wire logic [2:0]  port_width_select,
    input  wire logic [15:0] asic_func,
    input  wire logic [4:0]  width_sel_unit_a,
    input  wire logic [4:0]  width_sel_unit_b,
    input  wire logic [19:0] unit_b,
    output logic [15:0]      shared_pins,
    output logic [19:0]      dual_pins,
    output logic             trace_sample_clock,
    output logic [19:0]      last_sample,
    output logic [15:0]      sample_count
);
    logic        div_q;
    logic [4:0]  pkt_pins;
    logic [19:0] unit_a;

    assign unit_a = {pipeline_status_out, trace_sync_out, trace_packet_out};

    always_comb begin
        case (port_width_select)
            3'h1: pkt_pins = 5'h08;
            3'h2: pkt_pins = 5'h10;
            default: pkt_pins = 5'h04;
        endcase
        for (int j = 0; j < 16; j++) begin
            shared_pins[j] = (trace_port_enable && j < pkt_pins) ? trace_packet_out[j] : asic_func[j];
        end
    end

    always_comb begin
        if (width_sel_unit_b == 5'h15) begin
            dual_pins = unit_b;
        end else if (width_sel_unit_a == 5'h0D && width_sel_unit_b == 5'h09) begin
            dual_pins = {unit_b[19:16], unit_b[3:0], unit_a[19:16], unit_a[7:0]};
        end else if (width_sel_unit_a == 5'h09 && width_sel_unit_b == 5'h0D) begin
            dual_pins = {unit_a[19:16], unit_a[3:0], unit_b[19:16], unit_b[7:0]};
        end else begin
            dual_pins = unit_a;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            div_q <= 1'b0;
        else if (half_rate_enable)
            div_q <= ~div_q;
    end

    assign trace_sample_clock = half_rate_enable ? div_q : aclk;

    always @(negedge aclk) begin
        if (!aresetn) begin
            last_sample  <= 20'h0;
            sample_count <= 16'h0;
        end else if (trace_port_enable) begin
            last_sample  <= {pipeline_status_out, trace_sync_out, trace_packet_out};
            sample_count <= sample_count + 16'h1;
        end
    end
endmodule
`default_nettype wire

// file: tb/test_trace_port_pin_sharing.sv
/*
 * Self-checking bench for the trace port control block over AXI4-Lite.
 * Assumes the design answers every request within a few cycles.
 */
`timescale 1ns/100ps
`default_nettype none
module test_trace_port_pin_sharing;
    import tps_pkg::*;
    logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic              awready, wready, bvalid, arready, rvalid, trace_sync_in;
    logic              context_id_write, trace_sync_out, trace_port_enable;
    logic              half_rate_enable, trace_sample_clock;
    logic [AXI_AW-1:0] awaddr, araddr;
    logic [31:0]       wdata, rdata, context_id_in, rd;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp, port_format_select, rsp;
    logic [7:0]        capability_straps;
    logic [2:0]        pipeline_status_in, pipeline_status_out, port_width_select;
    logic [15:0]       trace_packet_in, trace_packet_out, sample_count;
    logic [19:0]       last_sample, unit_b, dual_pins;
    logic [15:0]       asic_func, shared_pins;
    logic [4:0]        width_sel_unit_a, width_sel_unit_b;
    int                bad_count, total_checks;

    tps_trace_port_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .capability_straps(capability_straps), .pipeline_status_in(pipeline_status_in),
        .trace_sync_in(trace_sync_in), .trace_packet_in(trace_packet_in),
        .context_id_in(context_id_in), .context_id_write(context_id_write),
        .pipeline_status_out(pipeline_status_out), .trace_sync_out(trace_sync_out),
        .trace_packet_out(trace_packet_out), .trace_port_enable(trace_port_enable),
        .port_width_select(port_width_select), .port_format_select(port_format_select),
        .half_rate_enable(half_rate_enable));

    tps_capture_model i_model (.aclk(aclk), .aresetn(aresetn), .half_rate_enable(half_rate_enable),
        .trace_port_enable(trace_port_enable), .pipeline_status_out(pipeline_status_out),
        .trace_sync_out(trace_sync_out), .trace_packet_out(trace_packet_out),
        .port_width_select(port_width_select), .asic_func(asic_func), .width_sel_unit_a(width_sel_unit_a),
        .width_sel_unit_b(width_sel_unit_b), .unit_b(unit_b), .shared_pins(shared_pins), .dual_pins(dual_pins),
        .trace_sample_clock(trace_sample_clock), .last_sample(last_sample),
        .sample_count(sample_count));

    always #10 aclk = ~aclk;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run();
        if (bad_count == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        r = 2'h3;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
        check("write latency", 32'(n), 32'd3);
    endtask

    task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        r = 2'h3;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        r = rresp;
        d = rdata;
        rready <= 1'b0;
        check("read latency", 32'(n), 32'd2);
    endtask

    task automatic t_idle();
        check("enable", {31'h0, trace_port_enable}, 32'h0);
        check("width", {29'h0, port_width_select}, 32'h0);
        check("format", {30'h0, port_format_select}, 32'h0);
        check("half", {31'h0, half_rate_enable}, 32'h0);
        axr(OFS_CTRL, rd, rsp);
        check("ctrl reset", rd, 32'h0);
    endtask

    task automatic t_straps();
        axr(OFS_STRAPS, rd, rsp);
        check("straps", rd, 32'h0000_00BA);
        check("strap width code", {29'h0, rd[2:0]}, {29'h0, WIDTH_16BIT});
        capability_straps <= 8'h41;
        axw(OFS_STRAPS, 32'h0, rsp);
        check("strap write resp", {30'h0, rsp}, {30'h0, RESP_OKAY});
        axr(OFS_STRAPS, rd, rsp);
        check("straps new", rd, 32'h0000_0041);
        check("enable kept", {31'h0, trace_port_enable}, 32'h0);
    endtask

    task automatic t_ctrl();
        logic [31:0] v;
        logic        c;
        axw(OFS_CTRL, 32'hFFFF_FFFF, rsp);
        axr(OFS_CTRL, rd, rsp);
        check("ctrl mask", rd, 32'h0003_0171);
        for (int i = 0; i < 3; i++) begin
            v = (32'(i) << 16) | (32'(i & 1) << 8) | (32'(i) << 4) | 32'h1;
            axw(OFS_CTRL, v, rsp);
            check("ctrl resp", {30'h0, rsp}, 32'h0);
            check("enable", {31'h0, trace_port_enable}, 32'h1);
            check("width", {29'h0, port_width_select}, 32'(i));
            check("format", {30'h0, port_format_select}, 32'(i));
            check("half", {31'h0, half_rate_enable}, 32'(i & 1));
            axr(OFS_CTRL, rd, rsp);
            check("ctrl read", rd, v);
            @(negedge aclk);
            c = trace_sample_clock;
            @(negedge aclk);
            if (i == 1) check("trace clock", {31'h0, trace_sample_clock}, {31'h0, ~c});
        end
    endtask

    task automatic t_stream(input logic en);
        logic [19:0] p;
        logic [15:0] cnt;
        for (int k = 0; k < 4; k++) begin
            p = 20'hA5C3E + 20'(k * 'h1F7);
            @(posedge aclk);
            {pipeline_status_in, trace_sync_in, trace_packet_in} <= p;
            @(posedge aclk);
            #1;
            check("trace out", {12'h0, pipeline_status_out, trace_sync_out, trace_packet_out},
                  en ? {12'h0, p} : 32'h0);
            @(negedge aclk);
            #1;
            if (en) check("captured", {12'h0, last_sample}, {12'h0, p});
            if (k == 0) cnt = sample_count;
        end
        if (en) check("sample count", 32'(sample_count - cnt), 32'd6);
        check("width kept", {29'h0, port_width_select}, en ? 32'h2 : 32'h0);
    endtask

    task automatic t_context();
        @(posedge aclk);
        context_id_in <= 32'hA5C3_0F12;
        context_id_write <= 1'b1;
        @(posedge aclk);
        context_id_write <= 1'b0;
        axr(OFS_CONTEXT, rd, rsp);
        check("context", rd, 32'hA5C3_0F12);
    endtask

    task automatic t_errors();
        axw(12'h00C, 32'h1234_5678, rsp);
        check("bad write resp", {30'h0, rsp}, 32'h2);
        axr(12'hFFC, rd, rsp);
        check("bad read resp", {30'h0, rsp}, 32'h2);
        check("bad read data", rd, 32'h0);
        check("enable kept", {31'h0, trace_port_enable}, 32'h1);
    endtask

    task automatic t_stall();
        @(posedge aclk);
        awaddr <= OFS_CTRL;
        wdata <= 32'hFFFF_FF10;
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (awvalid || wvalid);
        repeat (3) @(posedge aclk);
        check("held bvalid", {31'h0, bvalid}, 32'h1);
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        check("stalled write resp", {30'h0, bresp}, 32'h0);
        check("strobe enable", {31'h0, trace_port_enable}, 32'h0);
        check("strobe width", {29'h0, port_width_select}, 32'h1);
        check("format kept", {30'h0, port_format_select}, 32'h2);
        araddr <= OFS_CTRL;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        repeat (3) @(posedge aclk);
        check("held rvalid", {31'h0, rvalid}, 32'h1);
        rready <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        check("stalled read", rdata, 32'h0002_0010);
    endtask

    task automatic t_pins();
        @(posedge aclk);
        asic_func <= 16'h5A5A;
        unit_b <= 20'h6C3E7;
        {pipeline_status_in, trace_sync_in, trace_packet_in} <= 20'hB1234;
        axw(OFS_CTRL, 32'h0000_0011, rsp);
        @(posedge aclk);
        #1;
        check("shared pins 8", {16'h0, shared_pins}, 32'h0000_5A34);
        check("dual default", {12'h0, dual_pins}, 32'h000B_1234);
        @(posedge aclk);
        width_sel_unit_a <= 5'h0D;
        width_sel_unit_b <= 5'h09;
        @(posedge aclk);
        #1;
        check("dual split", {12'h0, dual_pins}, 32'h0006_7B34);
        @(posedge aclk);
        width_sel_unit_a <= 5'h09;
        width_sel_unit_b <= 5'h0D;
        @(posedge aclk);
        #1;
        check("dual swapped", {12'h0, dual_pins}, 32'h000B_46E7);
        @(posedge aclk);
        width_sel_unit_b <= 5'h15;
        @(posedge aclk);
        #1;
        check("dual unit b", {12'h0, dual_pins}, 32'h0006_C3E7);
        axw(OFS_CTRL, 32'h0, rsp);
        #1;
        check("shared pins off", {16'h0, shared_pins}, 32'h0000_5A5A);
    endtask

    task automatic t_rst();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1;
        check("enable after reset", {31'h0, trace_port_enable}, 32'h0);
        check("width after reset", {29'h0, port_width_select}, 32'h0);
        axr(OFS_CTRL, rd, rsp);
        check("ctrl after reset", rd, 32'h0);
    endtask

    initial begin
        repeat (5000) @(posedge aclk);
        bad_count++;
        complete_run();
    end

    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
        {awaddr, araddr, wdata, wstrb, context_id_in, context_id_write} = 0;
        {pipeline_status_in, trace_sync_in, trace_packet_in} = 20'h0;
        {asic_func, unit_b, width_sel_unit_a, width_sel_unit_b} = 0;
        capability_straps = 8'hBA;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_idle();
        t_straps();
        t_stream(1'b0);
        t_ctrl();
        t_stream(1'b1);
        t_context();
        t_errors();
        t_stall();
        t_pins();
        t_rst();
        complete_run();
    end
endmodule
`default_nettype wire
